//--- shared/rce_map.svh
// Purpose: constants of the remote control encoder/decoder
// Assumes: 40 MHz clock
// Notes: included by the package, the top-level design file and the bench files
`ifndef RCE_MAP_SVH
`define RCE_MAP_SVH

// ==========================================================
// timing
`define RCE_CLK_MHZ 40
`define RCE_CHIP_US 100
`define RCE_CHIP_CYC ((`RCE_CHIP_US) * (`RCE_CLK_MHZ))
`define RCE_HALF_CYC ((`RCE_CHIP_CYC) / 2)
`define RCE_HOLD_MS 130
`define RCE_HOLD_CYC ((`RCE_HOLD_MS) * (`RCE_CLK_MHZ) * 1000)
`define RCE_SETTLE 2'h3

// ==========================================================
// packet layout, counted in chips
`define RCE_GAP_CHIPS 8'h08
`define RCE_GAP_MIN 8'h06
`define RCE_START_CHIPS 8'h04
`define RCE_PKT_CHIPS 8'h94
`define RCE_PKT_MSB 6'h23
`define RCE_COPIES 2'h3
`define RCE_START_PAT 4'hF
`define RCE_LEG_ONE 4'hE
`define RCE_LEG_ZERO 4'h8
`define RCE_SER_ONE 4'hC
`define RCE_SER_ZERO 4'h3

// ==========================================================
// bit types and strap codes
`define RCE_SYM_ZERO 2'h0
`define RCE_SYM_OPEN 2'h1
`define RCE_SYM_ONE 2'h3
`define RCE_ACFG_ONE_OPEN 2'h1
`define RCE_ACFG_OPEN_ZERO 2'h2

// ==========================================================
// register map
`define RCE_OFF_CTRL 8'h00
`define RCE_OFF_STATUS 8'h04
`define RCE_OFF_INT_STAT 8'h08
`define RCE_OFF_INT_MASK 8'h0C
`define RCE_INT_W 4
`define RCE_CTRL_RST 1'h1

`endif

//--- shared/rce_pkg.sv
// Purpose: types of the remote control encoder/decoder
// Assumes: rce_map.svh holds all figures
// Notes: chip patterns are sent most significant chip first
`default_nettype none
`include "rce_map.svh"

package rce_pkg;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_ROLE = 3'b000,
		ST_IDLE = 3'b001,
		ST_GAP = 3'b010,
		ST_SEND = 3'b011,
		ST_ARM = 3'b100,
		ST_RX = 3'b101,
		ST_EVAL = 3'b110
	} rce_state_e;

	typedef struct packed {
		logic proto;
		logic role;
		logic dlow;
		logic [1:0] acfg;
		logic te;
		logic [9:0] addr;
		logic [7:0] data;
	} rce_pins_s;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
	} rce_pkt_s;

	// four chips for one packet bit in the chosen format
	function automatic logic [3:0] rce_chip_code(input logic proto, input logic bit_v);
		if (proto) begin
			rce_chip_code = bit_v ? `RCE_SER_ONE : `RCE_SER_ZERO;
		end else begin
			rce_chip_code = bit_v ? `RCE_LEG_ONE : `RCE_LEG_ZERO;
		end
	endfunction

endpackage

`default_nettype wire

//--- design/rce_sync.sv
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: levels may change at any time
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none

module rce_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (i_ce) begin
			meta_ff <= i_d;
			sync_ff <= meta_ff;
		end
	end

	assign o_q = sync_ff;

endmodule

`default_nettype wire

//--- design/rce_top.sv
// Purpose: pin-configured remote control encoder/decoder with an AHB-Lite side port
// Assumes: 40 MHz clock, synchronous active-low reset, straps steady
// Notes: packet is start chips then 10 address and 8 data symbols
//
// Functional notes
// R1: protocol_select low legacy, high serial format
// R2: role_select high encoder, low decoder
// R3: role sampled once after power-up
// R4: encoder captures data lines on enable rise
// R5: decoder drives data only after valid packet
// R6: data_low_meaning picks zero or open
// R7: two address straps pick address bit types
// R8: local address from ten address lines
// R9: encoder records inputs, sends packet three times
// R10: decoder reads shared pin as serial input
// R11: encoder drives shared pin with packet stream
// R12: decoder drives shared pin as valid indicator
// R13: all inputs driven, no internal pulls
// R14: data lines inputs as encoder, outputs decoder
// R15: two matching packets before first activation
// R16: serial decoder holds outputs for 130 ms
// R17: reject all-high or all-low address packets
// R18: every pin input passes two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.svh"

module rce_top
	import rce_pkg::*;
#(
	parameter int unsigned HOLD_CYC = `RCE_HOLD_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_protocol_select,
	input wire logic i_role_select,
	input wire logic i_data_low_meaning,
	input wire logic i_address_type_sel_lo,
	input wire logic i_address_type_sel_hi,
	input wire logic [9:0] i_local_address_lines,
	input wire logic [7:0] i_data_lines,
	output logic [7:0] o_data_lines,
	output logic [7:0] o_data_lines_oe,
	input wire logic i_transmit_enable_or_serial_in,
	output logic o_encoded_out_or_valid,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_irq
);

	// ==========================================================
	// pin synchronisation
	rce_pins_s raw_pins;
	rce_pins_s s_pins;

	assign raw_pins = '{proto: i_protocol_select, role: i_role_select, dlow: i_data_low_meaning,
		acfg: {i_address_type_sel_hi, i_address_type_sel_lo}, te: i_transmit_enable_or_serial_in,
		addr: i_local_address_lines, data: i_data_lines};

	// inputs are expected at firm levels; no pulls exist here [R13]
	rce_sync #(.WIDTH($bits(rce_pins_s))) u_sync ( // [R18]
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_d(raw_pins),
		.o_q(s_pins)
	);

	// ==========================================================
	// state
	rce_state_e state_ff, nxt_state;
	logic [11:0] cyc_ff, nxt_cyc;
	logic [7:0] chip_ff, nxt_chip;
	logic [1:0] rep_ff, nxt_rep;
	logic [1:0] settle_ff, nxt_settle;
	logic role_ok_ff, nxt_role_ok;
	logic role_enc_ff, nxt_role_enc;
	logic proto_ff, nxt_proto;
	rce_pkt_s pkt_ff, nxt_pkt;
	logic [3:0] chips_ff, nxt_chips;
	logic err_ff, nxt_err;
	logic tx_ff, nxt_tx;
	logic te_prev_ff;
	logic prev_ok_ff;
	rce_pkt_s prev_pkt_ff;
	logic valid_ff;
	logic [7:0] dout_ff;
	logic [22:0] hold_ff;
	logic ctrl_en_ff;
	logic [`RCE_INT_W-1:0] int_stat_ff;
	logic [`RCE_INT_W-1:0] int_mask_ff;
	logic wr_pend_ff;
	logic [7:0] waddr_ff;
	logic [31:0] hrdata_ff;
	logic ev_tx_done;

	// ==========================================================
	// local symbols and received data
	rce_pkt_s local_pkt;
	logic [7:0] rx_data;

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_sym
			// address bit type from the two straps [R7] [R8]
			assign local_pkt.addr[2*gi+:2] = s_pins.addr[gi] ?
				((s_pins.acfg == `RCE_ACFG_OPEN_ZERO) ? `RCE_SYM_OPEN : `RCE_SYM_ONE) :
				((s_pins.acfg == `RCE_ACFG_ONE_OPEN) ? `RCE_SYM_OPEN : `RCE_SYM_ZERO);
			if (gi < 8) begin : g_data
				// a low data line is zero or open [R6]
				assign local_pkt.data[2*gi+:2] = s_pins.data[gi] ? `RCE_SYM_ONE :
					(s_pins.dlow ? `RCE_SYM_ZERO : `RCE_SYM_OPEN);
				// open symbols come out as low [R6]
				assign rx_data[gi] = pkt_ff.data[2*gi+:2] == `RCE_SYM_ONE;
			end
		end
	endgenerate

	// ==========================================================
	// chip timing and selection
	wire logic chip_end = cyc_ff == 12'(`RCE_CHIP_CYC - 1);
	wire logic mid_chip = cyc_ff == 12'(`RCE_HALF_CYC);
	wire logic [11:0] cyc_step = chip_end ? 12'h000 : cyc_ff + 12'h001;
	wire logic [7:0] chip_step = chip_end ? chip_ff + 8'h01 : chip_ff;
	wire logic start_win = chip_ff < `RCE_START_CHIPS;
	wire logic last_chip = chip_ff == `RCE_PKT_CHIPS - 8'h01;
	wire logic [7:0] body_chip = chip_ff - `RCE_START_CHIPS;
	wire logic [5:0] bit_idx = body_chip[7:2];
	wire logic tx_bit = pkt_ff[`RCE_PKT_MSB - bit_idx];
	wire logic [3:0] tx_code = rce_chip_code(proto_ff, tx_bit);
	wire logic [3:0] rx_grp = {chips_ff[2:0], s_pins.te};
	wire logic [3:0] rx_one = rce_chip_code(proto_ff, 1'b1);
	wire logic [3:0] rx_zero = rce_chip_code(proto_ff, 1'b0);
	wire logic te_rise = s_pins.te && !te_prev_ff;

	// ==========================================================
	// packet checks
	wire logic dec_eval = state_ff == ST_EVAL;
	wire logic addr_match = pkt_ff.addr == local_pkt.addr;
	wire logic addr_flat = pkt_ff.addr == {10{pkt_ff.addr[1:0]}};
	wire logic pkt_good = !err_ff && addr_match && !addr_flat; // [R17]
	wire logic pkt_twice = pkt_good && prev_ok_ff && (pkt_ff == prev_pkt_ff); // [R15]
	wire logic take = dec_eval && (proto_ff && valid_ff ? pkt_good : pkt_twice); // [R5] [R15]
	wire logic drop_legacy = dec_eval && !proto_ff && !pkt_twice;
	wire logic hold_exp = valid_ff && (hold_ff == 23'(HOLD_CYC - 1));

	// ==========================================================
	// sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cyc = cyc_ff;
		nxt_chip = chip_ff;
		nxt_rep = rep_ff;
		nxt_settle = settle_ff;
		nxt_role_ok = role_ok_ff;
		nxt_role_enc = role_enc_ff;
		nxt_proto = proto_ff;
		nxt_pkt = pkt_ff;
		nxt_chips = chips_ff;
		nxt_err = err_ff;
		nxt_tx = 1'b0;
		ev_tx_done = 1'b0;
		case (state_ff)
			ST_ROLE: begin
				// wait until the synchroniser holds true pin levels
				nxt_settle = settle_ff + 2'h1;
				if (settle_ff == `RCE_SETTLE) begin
					nxt_role_ok = 1'b1;
					nxt_role_enc = s_pins.role; // [R2] [R3]
					nxt_state = s_pins.role ? ST_IDLE : ST_GAP;
					nxt_cyc = 12'h000;
					nxt_chip = 8'h00;
				end
			end
			ST_IDLE: begin
				if (ctrl_en_ff && te_rise) begin
					nxt_pkt = local_pkt; // [R4] [R9]
					nxt_proto = s_pins.proto; // [R1]
					nxt_rep = 2'h0;
					nxt_cyc = 12'h000;
					nxt_chip = 8'h00;
					nxt_state = ST_GAP;
				end
			end
			ST_GAP: begin
				nxt_cyc = cyc_step;
				nxt_chip = chip_step;
				if (role_enc_ff) begin
					if (chip_end && chip_ff == `RCE_GAP_CHIPS - 8'h01) begin
						nxt_chip = 8'h00;
						nxt_state = ST_SEND;
					end
				end else if (s_pins.te) begin
					// decoder: the gap must be low without a break
					nxt_cyc = 12'h000;
					nxt_chip = 8'h00;
				end else if (chip_end && chip_ff == `RCE_GAP_MIN - 8'h01) begin
					nxt_state = ST_ARM;
				end
			end
			ST_SEND: begin
				nxt_cyc = cyc_step;
				nxt_chip = chip_step;
				nxt_tx = start_win ? 1'b1 : tx_code[2'h3 - chip_ff[1:0]]; // [R11]
				if (chip_end && last_chip) begin
					nxt_chip = 8'h00;
					nxt_state = ST_GAP;
					if (rep_ff == `RCE_COPIES - 2'h1) begin // [R9]
						ev_tx_done = 1'b1;
						nxt_rep = 2'h0;
						if (ctrl_en_ff && s_pins.te) begin
							nxt_pkt = local_pkt; // [R9]
							nxt_proto = s_pins.proto; // [R1]
						end else begin
							nxt_state = ST_IDLE;
						end
					end else begin
						nxt_rep = rep_ff + 2'h1;
					end
				end
			end
			ST_ARM: begin
				if (ctrl_en_ff && s_pins.te) begin
					nxt_cyc = 12'h000;
					nxt_chip = 8'h00;
					nxt_err = 1'b0;
					nxt_proto = s_pins.proto; // [R1]
					nxt_state = ST_RX;
				end
			end
			ST_RX: begin
				nxt_cyc = cyc_step;
				nxt_chip = chip_step;
				if (mid_chip) begin
					nxt_chips = rx_grp; // [R10]
					if (chip_ff[1:0] == 2'h3) begin
						if (start_win) begin
							nxt_err = err_ff | (rx_grp != `RCE_START_PAT);
						end else begin
							nxt_pkt = {pkt_ff[34:0], rx_grp == rx_one}; // [R1]
							nxt_err = err_ff | ((rx_grp != rx_one) && (rx_grp != rx_zero));
						end
						if (last_chip) begin
							nxt_state = ST_EVAL;
						end
					end
				end
			end
			ST_EVAL: begin
				nxt_cyc = 12'h000;
				nxt_chip = 8'h00;
				nxt_state = ST_GAP;
			end
			default: begin
				nxt_state = ST_ROLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_ff <= ST_ROLE;
			cyc_ff <= 12'h000;
			chip_ff <= 8'h00;
			rep_ff <= 2'h0;
			settle_ff <= 2'h0;
			role_ok_ff <= 1'b0;
			role_enc_ff <= 1'b0;
			proto_ff <= 1'b0;
			pkt_ff <= '0;
			chips_ff <= 4'h0;
			err_ff <= 1'b0;
			tx_ff <= 1'b0;
			te_prev_ff <= 1'b0;
		end else if (i_ce) begin
			state_ff <= nxt_state;
			cyc_ff <= nxt_cyc;
			chip_ff <= nxt_chip;
			rep_ff <= nxt_rep;
			settle_ff <= nxt_settle;
			role_ok_ff <= nxt_role_ok;
			role_enc_ff <= nxt_role_enc;
			proto_ff <= nxt_proto;
			pkt_ff <= nxt_pkt;
			chips_ff <= nxt_chips;
			err_ff <= nxt_err;
			tx_ff <= nxt_tx;
			te_prev_ff <= s_pins.te;
		end
	end

	// ==========================================================
	// decoder outputs and hold timer
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			prev_ok_ff <= 1'b0;
			prev_pkt_ff <= '0;
			valid_ff <= 1'b0;
			dout_ff <= 8'h00;
			hold_ff <= 23'h000000;
		end else if (i_ce) begin
			if (dec_eval) begin
				prev_ok_ff <= pkt_good;
				prev_pkt_ff <= pkt_ff;
			end
			if (take) begin
				valid_ff <= 1'b1; // [R12]
				dout_ff <= rx_data; // [R5]
				hold_ff <= 23'h000000; // [R16]
			end else if (drop_legacy || hold_exp) begin // [R16]
				valid_ff <= 1'b0;
				dout_ff <= 8'h00;
				hold_ff <= 23'h000000;
			end else if (valid_ff) begin
				hold_ff <= hold_ff + 23'h000001;
			end
		end
	end

	wire logic dec_role = role_ok_ff && !role_enc_ff;
	assign o_data_lines = dout_ff;
	assign o_data_lines_oe = {8{dec_role}}; // [R14]
	assign o_encoded_out_or_valid = role_enc_ff ? tx_ff : valid_ff; // [R11] [R12]

	// ==========================================================
	// AHB-Lite slave, zero wait states while enabled
	wire logic ahb_take = i_hsel && i_htrans[1] && i_hready;
	wire logic [7:0] rd_addr = i_haddr[7:0];
	wire logic busy = (state_ff == ST_SEND) || (state_ff == ST_RX);
	wire logic [31:0] status_word = {16'h0000, dout_ff, 3'h0, s_pins.proto, busy, valid_ff,
		role_enc_ff, role_ok_ff};
	wire logic [31:0] rd_data =
		(rd_addr == `RCE_OFF_CTRL) ? {31'h00000000, ctrl_en_ff} :
		(rd_addr == `RCE_OFF_STATUS) ? status_word :
		(rd_addr == `RCE_OFF_INT_STAT) ? {28'h0000000, int_stat_ff} :
		(rd_addr == `RCE_OFF_INT_MASK) ? {28'h0000000, int_mask_ff} : 32'h00000000;
	wire logic wr_ctrl = wr_pend_ff && (waddr_ff == `RCE_OFF_CTRL);
	wire logic wr_clr = wr_pend_ff && (waddr_ff == `RCE_OFF_INT_STAT);
	wire logic wr_mask = wr_pend_ff && (waddr_ff == `RCE_OFF_INT_MASK);
	wire logic [`RCE_INT_W-1:0] int_set = {hold_exp && !take, dec_eval && !pkt_good, take, ev_tx_done};
	wire logic [`RCE_INT_W-1:0] int_clr = wr_clr ? i_hwdata[`RCE_INT_W-1:0] : '0;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wr_pend_ff <= 1'b0;
			waddr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			ctrl_en_ff <= `RCE_CTRL_RST;
			int_mask_ff <= '0;
			int_stat_ff <= '0;
		end else if (i_ce) begin
			wr_pend_ff <= ahb_take && i_hwrite;
			if (ahb_take) begin
				waddr_ff <= rd_addr;
			end
			if (ahb_take && !i_hwrite) begin
				hrdata_ff <= rd_data;
			end
			if (wr_ctrl) begin
				ctrl_en_ff <= i_hwdata[0];
			end
			if (wr_mask) begin
				int_mask_ff <= i_hwdata[`RCE_INT_W-1:0];
			end
			// a new event beats a clear in the same cycle
			int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
		end
	end

	assign o_hrdata = hrdata_ff;
	assign o_hreadyout = i_ce;
	assign o_hresp = 1'b0;
	assign o_irq = |(int_stat_ff & int_mask_ff);

endmodule

`default_nettype wire

//--- tb/rce_top_props.sv
// Purpose: pin checker of the encoder/decoder
// Assumes: one clock, synchronous active-low reset
// Notes: chip grid is only checked inside a packet, not across the gap
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.svh"
module rce_top_props (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_transmit_enable_or_serial_in,
	input wire logic [7:0] o_data_lines,
	input wire logic [7:0] o_data_lines_oe,
	input wire logic o_encoded_out_or_valid,
	input wire logic o_hreadyout,
	input wire logic o_hresp
);
	// ==========================================================
	// helper counters
	logic [16:0] run_ff;
	logic [16:0] si_run_ff;
	logic [3:0] rst_cnt_ff;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			run_ff <= 17'h0;
			si_run_ff <= 17'h0;
			rst_cnt_ff <= 4'h0;
		end else if (i_ce) begin
			run_ff <= $changed(o_encoded_out_or_valid) ? 17'h1 : run_ff + {16'h0, run_ff != 17'h1FFFF};
			si_run_ff <= $changed(i_transmit_enable_or_serial_in) ? 17'h1 : si_run_ff + {16'h0, si_run_ff != 17'h1FFFF};
			rst_cnt_ff <= rst_cnt_ff + {3'h0, rst_cnt_ff != 4'hF};
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_oe_uniform: assert property (o_data_lines_oe == 8'h00 || o_data_lines_oe == 8'hFF)
		else $error("data line enables split");
	a_role_locked: assert property ($changed(o_data_lines_oe) |-> $past(o_data_lines_oe) == 8'h00)
		else $error("role changed after it was chosen");
	a_role_delay: assert property ($changed(o_data_lines_oe) |-> rst_cnt_ff >= 4'h3 && rst_cnt_ff <= 4'h6)
		else $error("role chosen at the wrong time");
	a_data_idle_zero: assert property (o_data_lines_oe == 8'h00 |-> o_data_lines == 8'h00)
		else $error("data driven without decoder role");
	a_data_with_valid: assert property (o_data_lines != 8'h00 |-> o_encoded_out_or_valid && o_data_lines_oe == 8'hFF)
		else $error("data shown without valid");
	a_chip_grid: assert property (
		$changed(o_encoded_out_or_valid) && o_data_lines_oe == 8'h00 && run_ff < 17'h07530
		|-> run_ff % `RCE_CHIP_CYC == 0)
		else $error("encoder output off the chip grid");
	a_valid_from_line: assert property (
		$rose(o_encoded_out_or_valid) && o_data_lines_oe == 8'hFF |-> si_run_ff < 17'h09C40)
		else $error("valid raised on a quiet line");
	a_ready_ce: assert property (o_hreadyout == i_ce)
		else $error("ready does not follow clock enable");
	a_resp_okay: assert property (!o_hresp)
		else $error("bus response not okay");
endmodule
`default_nettype wire

//--- tb/rce_rf_tx_model.sv
// Purpose: transmitter stand-in that takes the encoded chip stream
// Assumes: line idles low before a burst, chips of RCE_CHIP_CYC cycles
// Notes: measures the gap from arm and samples each chip in its middle
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.svh"
module rce_rf_tx_model (
	input wire logic i_clk,
	input wire logic i_arm,
	input wire logic i_line,
	output int o_gap,
	output logic [7:0] o_chips,
	output int o_count
);
	// ==========================================================
	// chip sampler
	int t;
	logic seen;
	always @(posedge i_clk) begin
		if (!i_arm) begin
			t <= 0;
			seen <= 1'b0;
			o_gap <= 0;
			o_count <= 0;
			o_chips <= 8'h00;
		end else if (!seen) begin
			o_gap <= o_gap + 1;
			seen <= i_line;
			t <= 1;
		end else begin
			t <= t + 1;
			if (t % `RCE_CHIP_CYC == `RCE_HALF_CYC) begin
				o_chips <= {o_chips[6:0], i_line};
				o_count <= o_count + 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench of the encoder/decoder
// Assumes: 40 MHz clock, one bus slave
// Notes: a full packet is too long to run, only its head is checked
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.svh"
module tb_top
	import rce_pkg::*;
;
	`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
		$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	rce_pins_s p = '0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] v;
	wire [7:0] dout;
	wire [7:0] oe;
	wire [31:0] hrdata;
	wire out;
	wire hrdy;
	wire hresp;
	wire irq;
	wire [7:0] chips;
	int gap;
	int cnt;
	int bad_count = 0;
	int checked = 0;
	integer seed = 32'ha3179c14;
	// register model and read masks, one entry per word offset
	logic [31:0] regs [5] = '{32'h00000001, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
	logic [31:0] msk [5] = '{32'hFFFFFFFF, 32'h0000001F, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	always #12.5 clk = ~clk;
	// ==========================================================
	// design and far side
	rce_top #(.HOLD_CYC(2000)) rce_top_i (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
		.i_protocol_select(p.proto), .i_role_select(p.role), .i_data_low_meaning(p.dlow),
		.i_address_type_sel_lo(p.acfg[0]), .i_address_type_sel_hi(p.acfg[1]),
		.i_local_address_lines(p.addr), .i_data_lines(p.data), .o_data_lines(dout), .o_data_lines_oe(oe),
		.i_transmit_enable_or_serial_in(p.te), .o_encoded_out_or_valid(out), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .o_irq(irq));
	rce_rf_tx_model rce_rf_tx_model_i (.i_clk(clk), .i_arm(p.te), .i_line(out), .o_gap(gap),
		.o_chips(chips), .o_count(cnt));
	// ==========================================================
	// tasks
	task stop_test;
		$display("counts checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task reset(input logic r);
		p.role <= r;
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	// waits as long as the slave stretches; only the watchdog ends a hang
	task ahb(input logic w, input int a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		if (!w) `CHK(hrdata & msk[a / 4], regs[a / 4])
		else if (a == 0) regs[0] = d & 32'h1;
		else if (a == 8) regs[2] = regs[2] & ~d;
		else if (a == 12) regs[3] = d & 32'hF;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		reset(1'b1);
		regs[1] = 32'h3;
		for (int a = 0; a <= 16; a += 4) ahb(1'b0, a, 32'h0);
		ahb(1'b1, 12, 32'hF);
		ahb(1'b1, 8, 32'hF);
		ahb(1'b1, 16, 32'h5A);
		ahb(1'b1, 0, 32'h0);
		for (int a = 0; a <= 16; a += 4) ahb(1'b0, a, 32'h0);
		`CHK(irq, 1'b0)
		ahb(1'b1, 0, 32'h1);
		fork
			ahb(1'b0, 0, 32'h0);
			begin repeat (2) @(posedge clk); ce <= 1'b0; repeat (3) @(posedge clk); ce <= 1'b1; end
		join
		$display("register test done");
		for (int pr = 0; pr < 2; pr++) begin
			v = $random(seed);
			p.proto <= pr[0];
			p.acfg <= v[18:17];
			p.addr <= v[9:0];
			p.data <= v[16:9];
			reset(1'b1);
			p.te <= 1'b1;
			while (cnt < 6) @(posedge clk);
			`CHK(gap >= `RCE_GAP_CHIPS * `RCE_CHIP_CYC && gap <= `RCE_GAP_CHIPS * `RCE_CHIP_CYC + 32'h0A, 1'b1)
			// top address line leads: a one bit unless it is low or high means open
			`CHK(chips[5:0], {4'hF, (v[9] && v[18:17] != 2'h2) ? 2'h3 : (pr[0] ? 2'h0 : 2'h2)})
			`CHK(oe, 8'h00)
			regs[1] = {27'h0, pr[0], 4'hB};
			ahb(1'b0, 4, 32'h0);
			p.te <= 1'b0;
			$display("encoder test %0d done", pr);
		end
		reset(1'b0);
		`CHK(oe, 8'hFF)
		p.role <= 1'b1;
		repeat (3000) begin @(posedge clk); v = $random(seed); p.te <= v[0]; end
		`CHK(oe, 8'hFF)
		`CHK(out, 1'b0)
		`CHK(dout, 8'h00)
		regs[1] = 32'h1;
		msk[1] = 32'h3;
		ahb(1'b0, 4, 32'h0);
		$display("decoder test done");
		stop_test();
	end
	initial begin
		// clean run needs about 112000 cycles
		#(25 * 150000);
		bad_count++;
		stop_test();
	end
endmodule
bind rce_top rce_top_props rce_top_props_i (.i_clk, .i_reset_n, .i_ce, .i_transmit_enable_or_serial_in,
	.o_data_lines, .o_data_lines_oe, .o_encoded_out_or_valid, .o_hreadyout, .o_hresp);
`default_nettype wire
